// [hw/tx_clk_map.svh]
`ifndef TX_CLK_MAP_SVH
`define TX_CLK_MAP_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------------
`define TXC_CTRL_ADDR      4'h0
`define TXC_STATUS_ADDR    4'h4

// Control register fields
`define TXC_CTRL_MASTER    0
`define TXC_CTRL_SHARED    1
`define TXC_CTRL_MUX       2
`define TXC_CTRL_FP_INV    3
`define TXC_CTRL_E1        4
`define TXC_CTRL_RESET     5'h00

// Status register fields
`define TXC_STAT_SEL_LSB   0
`define TXC_STAT_CLK_LSB   8
`define TXC_STAT_GEN       16

// ----------------------------------------------------------------------
// Rates and counts
// ----------------------------------------------------------------------
`define TXC_SYS_KHZ        64'd100000
`define TXC_T1_KHZ         64'd1544
`define TXC_E1_KHZ         64'd2048
// Phase step per system cycle for a master-mode link clock
`define TXC_NCO_STEP(khz)  ((64'(khz) << 32) / `TXC_SYS_KHZ)
// Phase step per reference half period for the generated T1-rate clock
`define TXC_GEN_STEP(n, base) \
    ((`TXC_T1_KHZ << 32) / (64'd2 * 64'(n) * (base)))
`define TXC_T1_FRAME_BITS  9'd193
`define TXC_E1_FRAME_BITS  9'd256

`endif

// [hw/tx_clk_pkg.sv]
package tx_clk_pkg;
    typedef logic [31:0] phase_t;
    typedef logic [8:0]  bit_count_t;
    typedef enum logic [1:0] {
        MODE_SLAVE  = 2'b00,
        MODE_MASTER = 2'b01,
        MODE_MUX    = 2'b10
    } tx_mode_e;
endpackage

// [hw/tx_sys_clocking.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Master mode drives each link clock, 1.544 or 2.048 MHz, samples on it.
// - Slave mode samples each link's data, signalling, frame pulse on its clock.
// - Shared-slave bit makes link 1 clock sample all eight links.
// - Multiplexed mode samples buses A/B and frame pulse on the shared clock.
// - Base-rate pin low means 1.544 MHz multiple, high means 2.048 MHz.
// - Multiplier pins 00,01,10,11 give 1,2,3,4 times the base rate.
// - Generator makes a 1.544 MHz clock from the reference on its own pin.
// - Oscillator output pin is the inverted, buffered oscillator input.
// - Frame pulse updated or sampled on link clock edge; polarity by invert bit.
`include "tx_clk_map.svh"

module tx_sys_clocking
    import tx_clk_pkg::*;
(
    input  wire logic        clock,               // 100 MHz system clock
    input  wire logic        rst,                 // Sync reset, active high
    // Avalon-MM slave
    input  wire logic [3:0]  address,             // Byte address
    input  wire logic        read,                // Read request
    input  wire logic        write,               // Write request
    input  wire logic [31:0] writedata,           // Write data
    output logic      [31:0] readdata,            // Read data
    output logic             waitrequest,         // Stall
    // Link pins
    input  wire logic [7:0]  tx_sys_clk_in,       // Link clock pin level
    output logic      [7:0]  tx_sys_clk_out,      // Link clock drive
    output logic      [7:0]  tx_sys_clk_oe,       // Link clock enable
    input  wire logic [7:0]  tx_sys_data,         // Data pins, mux buses
    input  wire logic [7:0]  tx_sys_signalling,   // Signalling, mux buses
    input  wire logic [7:0]  tx_sys_frame_pulse_in,  // Frame pulse level
    output logic      [7:0]  tx_sys_frame_pulse_out, // Frame pulse drive
    output logic      [7:0]  tx_sys_frame_pulse_oe,  // Frame pulse enable
    // Clock generator pins
    input  wire logic        ref_osc_in,          // Reference oscillator
    output logic             ref_osc_out,         // Inverted reference
    input  wire logic [2:0]  clk_sel,             // Reference select
    output logic             gen_t1_rate_clk_out, // Generated 1.544 MHz
    // Core side
    output logic      [7:0]  link_strobe,         // Per-link sample pulse
    output logic      [7:0]  link_data,           // Sampled data bits
    output logic      [7:0]  link_sig,            // Sampled signalling
    output logic      [7:0]  link_frame_start,    // Frame pulse, active high
    output logic             mux_strobe,          // Mux sample pulse
    output logic      [1:0]  mux_data_a,          // Sampled data bus A
    output logic      [1:0]  mux_data_b,          // Sampled data bus B
    output logic      [1:0]  mux_sig_a,           // Sampled sig bus A
    output logic      [1:0]  mux_sig_b,           // Sampled sig bus B
    output logic             mux_frame_start      // Mux frame, active high
);

    // ------------------------------------------------------------------
    // Control register and mode
    // ------------------------------------------------------------------
    logic [4:0] ctrl;
    tx_mode_e   mode;
    logic       rd_ack;
    logic [2:0] sel_cap;
    logic [7:0] clk_lvl;
    logic       gen_clk;

    // Mux mode wins, since it repurposes the link 1 pins
    always_comb begin
        if (ctrl[`TXC_CTRL_MUX])
            mode = MODE_MUX;
        else if (ctrl[`TXC_CTRL_MASTER])
            mode = MODE_MASTER;
        else
            mode = MODE_SLAVE;
    end

    // Every access is answered one cycle after it is presented
    assign waitrequest = (read | write) & ~rd_ack;

    // Writes land in the acknowledged cycle, when the master completes
    always_ff @(posedge clock) begin
        if (rst) begin
            rd_ack <= 1'b0;
            ctrl   <= `TXC_CTRL_RESET;
        end else begin
            rd_ack <= (read | write) & ~rd_ack;
            if (write && rd_ack && address == `TXC_CTRL_ADDR)
                ctrl <= writedata[4:0];
        end
    end

    // Read data; unmapped addresses read as zero
    always_ff @(posedge clock) begin
        if (rst) begin
            readdata <= 32'h0000_0000;
        end else if (read && !rd_ack) begin
            readdata <= 32'h0000_0000;
            unique case (address)
                `TXC_CTRL_ADDR:
                    readdata[4:0] <= ctrl;
                `TXC_STATUS_ADDR: begin
                    readdata[`TXC_STAT_SEL_LSB +: 3] <= sel_cap;
                    readdata[`TXC_STAT_CLK_LSB +: 8] <= clk_lvl;
                    readdata[`TXC_STAT_GEN]          <= gen_clk;
                end
                default:
                    readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [7:0] clk_m, dat_m, dat_s, sig_m, sig_s, fp_m, fp_s;
    logic [7:0] clk_prev;
    logic [2:0] sel_m, sel_s;
    logic       osc_m, osc_s, osc_prev;

    // Two flops on every asynchronous pin; only the ref_osc_out buffer takes ref_osc_in directly
    always_ff @(posedge clock) begin
        clk_m <= tx_sys_clk_in;
        clk_lvl <= clk_m;
        dat_m <= tx_sys_data;
        dat_s <= dat_m;
        sig_m <= tx_sys_signalling;
        sig_s <= sig_m;
        fp_m  <= tx_sys_frame_pulse_in;
        fp_s  <= fp_m;
        sel_m <= clk_sel;
        sel_s <= sel_m;
        osc_m <= ref_osc_in;
        osc_s <= osc_m;
    end

    // Released clock pins idle high, so start high: no false edge
    always_ff @(posedge clock) begin
        if (rst) begin
            clk_prev <= 8'hFF;
            osc_prev <= 1'b0;
        end else begin
            clk_prev <= clk_lvl;
            osc_prev <= osc_s;
        end
    end

    // ------------------------------------------------------------------
    // Master-mode link clock
    // ------------------------------------------------------------------
    phase_t     nco;
    logic       nco_prev;
    bit_count_t bit_cnt;
    logic       fp_act;

    // Phase accumulator; its top bit is the link clock
    always_ff @(posedge clock) begin
        if (rst) begin
            nco      <= 32'h0000_0000;
            nco_prev <= 1'b0;
        end else begin
            nco <= nco + (ctrl[`TXC_CTRL_E1]
                ? phase_t'(`TXC_NCO_STEP(`TXC_E1_KHZ))
                : phase_t'(`TXC_NCO_STEP(`TXC_T1_KHZ)));
            nco_prev <= nco[31];
        end
    end

    // Master drives all eight clocks; slave and mux only listen
    assign tx_sys_clk_out = {8{nco[31]}};
    assign tx_sys_clk_oe  = {8{mode == MODE_MASTER}};

    // Active edge per link; shared mode uses link 1's clock, mux mode gives no link edges
    logic [7:0] edge_own, edge_use;
    logic       master_edge;
    assign master_edge = nco[31] & ~nco_prev;
    assign edge_own    = clk_lvl & ~clk_prev;
    always_comb begin
        unique case (mode)
            MODE_MASTER: edge_use = {8{master_edge}};
            MODE_MUX:    edge_use = 8'h00;
            MODE_SLAVE:  edge_use = ctrl[`TXC_CTRL_SHARED]
                                  ? {8{edge_own[0]}}
                                  : edge_own;
            default:     edge_use = 8'h00;
        endcase
    end

    // Bit counter for the outgoing frame pulse
    always_ff @(posedge clock) begin
        if (rst || mode != MODE_MASTER)
            bit_cnt <= 9'd0;
        else if (master_edge)
            bit_cnt <= (bit_cnt == (ctrl[`TXC_CTRL_E1]
                        ? `TXC_E1_FRAME_BITS : `TXC_T1_FRAME_BITS) - 9'd1)
                     ? 9'd0 : bit_cnt + 9'd1;
    end

    // Frame pulse changes only on the link clock edge, polarity by invert
    assign fp_act = ctrl[`TXC_CTRL_FP_INV];
    always_ff @(posedge clock) begin
        if (rst)
            tx_sys_frame_pulse_out <= 8'h00;
        else if (master_edge)
            tx_sys_frame_pulse_out <= {8{(bit_cnt == 9'd0) ^ fp_act}};
    end
    assign tx_sys_frame_pulse_oe = {8{mode == MODE_MASTER}};

    // ------------------------------------------------------------------
    // Per-link sampling
    // ------------------------------------------------------------------
    // Inputs are taken on the active edge of the selected clock
    always_ff @(posedge clock) begin
        if (rst) begin
            link_strobe      <= 8'h00;
            link_data        <= 8'h00;
            link_sig         <= 8'h00;
            link_frame_start <= 8'h00;
        end else begin
            link_strobe <= edge_use;
            for (int i = 0; i < 8; i++) begin
                if (edge_use[i]) begin
                    link_data[i] <= dat_s[i];
                    link_sig[i]  <= sig_s[i];
                    link_frame_start[i] <= (mode == MODE_MASTER)
                        ? (bit_cnt == 9'd0)
                        : fp_s[i] ^ fp_act;
                end
            end
        end
    end

    // Multiplexed buses share the link pins and link 1's clock pin
    always_ff @(posedge clock) begin
        if (rst) begin
            mux_strobe      <= 1'b0;
            mux_data_a      <= 2'b00;
            mux_data_b      <= 2'b00;
            mux_sig_a       <= 2'b00;
            mux_sig_b       <= 2'b00;
            mux_frame_start <= 1'b0;
        end else begin
            mux_strobe <= (mode == MODE_MUX) & edge_own[0];
            if (mode == MODE_MUX && edge_own[0]) begin
                mux_data_a      <= {dat_s[4], dat_s[0]};
                mux_data_b      <= {dat_s[5], dat_s[1]};
                mux_sig_a       <= {sig_s[4], sig_s[0]};
                mux_sig_b       <= {sig_s[5], sig_s[1]};
                mux_frame_start <= fp_s[0] ^ fp_act;
            end
        end
    end

    // ------------------------------------------------------------------
    // Clock generator
    // ------------------------------------------------------------------
    phase_t gen_acc;
    phase_t gen_step;

    // Select pins are sampled while reset is asserted, then held
    always_ff @(posedge clock) begin
        if (rst)
            sel_cap <= sel_s;
    end

    // Step per reference half period, from base rate and multiple
    always_comb begin
        unique case (sel_cap)
            3'b000: gen_step = phase_t'(`TXC_GEN_STEP(1, `TXC_T1_KHZ));
            3'b001: gen_step = phase_t'(`TXC_GEN_STEP(2, `TXC_T1_KHZ));
            3'b010: gen_step = phase_t'(`TXC_GEN_STEP(3, `TXC_T1_KHZ));
            3'b011: gen_step = phase_t'(`TXC_GEN_STEP(4, `TXC_T1_KHZ));
            3'b100: gen_step = phase_t'(`TXC_GEN_STEP(1, `TXC_E1_KHZ));
            3'b101: gen_step = phase_t'(`TXC_GEN_STEP(2, `TXC_E1_KHZ));
            3'b110: gen_step = phase_t'(`TXC_GEN_STEP(3, `TXC_E1_KHZ));
            3'b111: gen_step = phase_t'(`TXC_GEN_STEP(4, `TXC_E1_KHZ));
        endcase
    end

    // Both reference edges tick the accumulator, so a 1x ratio still fits
    always_ff @(posedge clock) begin
        if (rst)
            gen_acc <= 32'h0000_0000;
        else if (osc_s != osc_prev)
            gen_acc <= gen_acc + gen_step;
    end

    assign gen_clk = gen_acc[31];

    // Output flop for the generated clock
    always_ff @(posedge clock) begin
        if (rst)
            gen_t1_rate_clk_out <= 1'b0;
        else
            gen_t1_rate_clk_out <= gen_clk;
    end

    // Pure inverting buffer; resampling at 100 MHz would distort the reference
    assign ref_osc_out = ~ref_osc_in;

endmodule

// [verification/tx_link_partner.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Far-side framer: 125 ns bit cell, clock still outside frames
// ----------------------------------------------------------------------
module tx_link_partner (
    input  wire logic       en,    // Run frames
    input  wire logic       inv,   // Frame pulse active low
    output logic            pclk,  // Link clock, pull-up when idle
    output logic      [7:0] pdata, // Data pins
    output logic      [7:0] psig,  // Signalling pins
    output logic      [7:0] pfp    // Frame pulse pins
);
    logic [7:0] cnt = 8'h00;
    // Data moves only on the falling edge, so it is steady around the
    // rising edge; idle lines toggle so no stale value looks valid
    initial begin
        pclk = 1'b1;
        pdata = 8'h00;
        psig = 8'h00;
        pfp = 8'hFF;
        forever begin
            #62.5;
            if (en) begin
                pclk = 1'b0;
                cnt = cnt + 8'h01;
                pdata = cnt;
                psig = {cnt[3:0], cnt[7:4]};
                pfp = {8{(cnt[2:0] == 3'h0) ^ inv}};
                #62.5;
                pclk = 1'b1;
            end else begin
                pdata = ~pdata;
                psig = ~psig;
                pfp = 8'hFF; // Pull-up
            end
        end
    end
endmodule

// [verification/tx_sys_clocking_chk.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------
module tx_sys_clocking_chk (
    input wire logic       clock,                  // System clock
    input wire logic       rst,                    // Sync reset
    input wire logic [7:0] tx_sys_clk_in,          // Link clock pins
    input wire logic [7:0] tx_sys_clk_out,         // Link clock drive
    input wire logic [7:0] tx_sys_clk_oe,          // Link clock enable
    input wire logic [7:0] tx_sys_frame_pulse_oe,  // Frame pulse enable
    input wire logic [7:0] tx_sys_data,            // Data pins
    input wire logic       ref_osc_in,             // Reference in
    input wire logic       ref_osc_out,            // Reference out
    input wire logic       gen_t1_rate_clk_out,    // Generated clock
    input wire logic [7:0] link_strobe,            // Link sample pulse
    input wire logic [7:0] link_data,              // Sampled data
    input wire logic       mux_strobe,             // Mux sample pulse
    input wire logic       mux_frame_start         // Mux frame flag
);
    logic [7:0] mcnt;
    logic [7:0] gcnt;
    logic       mprev;
    logic       gprev;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Cycles since last rise; zero until a full period can be seen
    always_ff @(posedge clock) begin
        mprev <= tx_sys_clk_out[0];
        if (rst || !tx_sys_clk_oe[0]) mcnt <= 8'h00;
        else if (tx_sys_clk_out[0] && !mprev) mcnt <= 8'h01;
        else if (mcnt != 8'h00 && mcnt != 8'hFF) mcnt <= mcnt + 8'h01;
    end
    always_ff @(posedge clock) begin
        gprev <= gen_t1_rate_clk_out;
        if (rst) gcnt <= 8'h00;
        else if (gen_t1_rate_clk_out && !gprev) gcnt <= 8'h01;
        else if (gcnt != 8'h00 && gcnt != 8'hFF) gcnt <= gcnt + 8'h01;
    end
    osc_inverted_a:
        assert property (ref_osc_out == !ref_osc_in) else $error("osc out");
    strobe_single_a:
        assert property (link_strobe[0] |=> !link_strobe[0])
        else $error("link strobe too long");
    mux_single_a:
        assert property (mux_strobe |=> !mux_strobe) else $error("mux pulse");
    strobe_edge_a:
        assert property ($rose(link_strobe[0]) && !tx_sys_clk_oe[0] |->
            $past(tx_sys_clk_in[0], 2) && !$past(tx_sys_clk_in[0], 6))
        else $error("strobe without link clock edge");
    data_capture_a:
        assert property (link_strobe[0] && !tx_sys_clk_oe[0] |=>
            link_data[0] == $past(tx_sys_data[0], 4))
        else $error("data not sampled at link edge");
    oe_pair_a:
        assert property (tx_sys_frame_pulse_oe == tx_sys_clk_oe &&
            tx_sys_clk_oe == {8{tx_sys_clk_oe[0]}}) else $error("enables");
    master_period_a:
        assert property ($rose(tx_sys_clk_out[0]) && mcnt != 8'h00 |->
            mcnt inside {[8'h30:8'h31], [8'h40:8'h41]})
        else $error("master link clock period");
    gen_period_a:
        assert property ($rose(gen_t1_rate_clk_out) && gcnt != 8'h00 |->
            gcnt inside {[8'h2F:8'h4B]}) else $error("generated period");
    cover property (mux_strobe && mux_frame_start);
    cover property (link_strobe[7] && !tx_sys_clk_oe[7]);
    cover property ($rose(tx_sys_clk_out[0]) && tx_sys_clk_oe[0]);
endmodule
bind tx_sys_clocking tx_sys_clocking_chk chk (.clock, .rst, .tx_sys_clk_in,
    .tx_sys_clk_out, .tx_sys_clk_oe, .tx_sys_frame_pulse_oe, .tx_sys_data,
    .ref_osc_in, .ref_osc_out, .gen_t1_rate_clk_out, .link_strobe,
    .link_data, .mux_strobe, .mux_frame_start);

// [verification/tx_sys_clocking_bench.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    fail_count++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tx_sys_clocking_bench;
    logic        clock = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
    logic        ref_osc_in = 1'b0, en = 1'b0, inv = 1'b0, pclk;
    logic        ref_osc_out, waitrequest, gen_t1_rate_clk_out;
    logic        mux_strobe, mux_frame_start;
    logic [1:0]  mux_data_a, mux_data_b, mux_sig_a, mux_sig_b;
    logic [2:0]  clk_sel = 3'h0;
    logic [3:0]  address = 4'h0;
    logic [31:0] writedata = 32'h0, readdata, q;
    logic [7:0]  tx_sys_clk_out, tx_sys_clk_oe, tx_sys_frame_pulse_out;
    logic [7:0]  tx_sys_frame_pulse_oe, link_strobe, link_data, link_sig;
    logic [7:0]  link_frame_start, tx_sys_data, tx_sys_signalling, pfp;
    logic [7:0]  lmask = 8'h00;
    logic [4:0]  mode_tab [5] = '{5'h00, 5'h18, 5'h02, 5'h04, 5'h0C};
    wire  [7:0]  tx_sys_clk_in, tx_sys_frame_pulse_in;
    int          fail_count = 0, n_checks = 0, n, c;
    real         half = 323.834;
    // ------------------------------------------------------------------
    // Pins: enables pick the driver, pull-ups hold released lines high
    // ------------------------------------------------------------------
    assign tx_sys_clk_in = (tx_sys_clk_oe & tx_sys_clk_out)
        | (~tx_sys_clk_oe & (~lmask | {8{pclk}}));
    assign tx_sys_frame_pulse_in = (tx_sys_frame_pulse_oe
        & tx_sys_frame_pulse_out) | (~tx_sys_frame_pulse_oe & pfp);
    tx_sys_clocking dut (.clock, .rst, .address, .read, .write, .writedata,
        .readdata, .waitrequest, .tx_sys_clk_in, .tx_sys_clk_out,
        .tx_sys_clk_oe, .tx_sys_data, .tx_sys_signalling,
        .tx_sys_frame_pulse_in, .tx_sys_frame_pulse_out,
        .tx_sys_frame_pulse_oe, .ref_osc_in, .ref_osc_out, .clk_sel,
        .gen_t1_rate_clk_out, .link_strobe, .link_data, .link_sig,
        .link_frame_start, .mux_strobe, .mux_data_a, .mux_data_b,
        .mux_sig_a, .mux_sig_b, .mux_frame_start);
    tx_link_partner far (.en(en), .inv(inv), .pclk(pclk),
        .pdata(tx_sys_data), .psig(tx_sys_signalling), .pfp(pfp));
    // Clocks: system and free-running reference oscillator
    initial begin
        forever #5 clock = ~clock;
    end
    initial begin
        forever #(half) ref_osc_in = ~ref_osc_in;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic timeout();
        fail_count++;
        print_verdict();
    endtask
    // One bus cycle: held until waitrequest is low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clock);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge clock);
            k++;
            if (k > 50) timeout();
        end while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic do_reset(input logic [2:0] s);
        @(posedge clock);
        rst <= 1'b1;
        clk_sel <= s;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
    endtask
    function automatic logic probe(input int w);
        case (w)
            0: return gen_t1_rate_clk_out;
            1: return tx_sys_clk_out[0];
            2: return tx_sys_frame_pulse_out[0] ^ inv;
            3: return link_strobe[7];
            default: return mux_strobe;
        endcase
    endfunction
    // Negedges from the first rise of a probe to its k-th further rise, both counted (cycles + 1)
    task automatic span(input int w, input int k);
        int r;
        int t;
        logic last;
        r = -1;
        t = 0;
        last = 1'b1;
        n = 0;
        while (r < k) begin
            @(negedge clock);
            if (probe(w) === 1'b1 && !last) r++;
            last = (probe(w) === 1'b1);
            if (r >= 0) n++;
            t++;
            if (t > 30000) timeout();
        end
    endtask
    task automatic sample(input int w);
        logic [7:0] e;
        span(w, 0);
        @(negedge clock);
        e = {tx_sys_data[4], tx_sys_data[0], tx_sys_data[5], tx_sys_data[1],
             tx_sys_signalling[4], tx_sys_signalling[0],
             tx_sys_signalling[5], tx_sys_signalling[1]};
        if (w == 4) begin
            `CHK("mux", e, {mux_data_a,mux_data_b,mux_sig_a,mux_sig_b});
            `CHK("mux frame", pfp[0] ^ inv, mux_frame_start);
        end else begin
            `CHK("data", tx_sys_data, link_data);
            `CHK("sig", tx_sys_signalling, link_sig);
            `CHK("frame", pfp ^ {8{inv}}, link_frame_start);
        end
    endtask
    initial begin
        do_reset(3'h0);
        bus(1'b1, 4'h0, 32'hFFFF_FFF6);
        bus(1'b1, 4'hC, 32'h0000_0001);
        bus(1'b0, 4'h0, 32'h0);
        `CHK("ctrl", 32'h0000_0016, q);
        bus(1'b0, 4'hC, 32'h0);
        `CHK("unmapped", 32'h0000_0000, q);
        clk_sel <= 3'h7;
        bus(1'b0, 4'h4, 32'h0);
        `CHK("sel held", 3'h0, q[2:0]);
        $display("test registers done");
        for (int s = 0; s < 8; s++) begin
            half = 500.0 / ((s[2] ? 2.048 : 1.544) * (s % 4 + 1));
            do_reset(s[2:0]);
            bus(1'b0, 4'h4, 32'h0);
            `CHK("sel", s[2:0], q[2:0]);
            // Generated edges snap to reference edges: one half period slack
            c = int'(half / 10.0) + 3;
            span(0, 16);
            n = n - 1037;
            `CHK("gen span", 1'b1, n >= -c && n <= c);
        end
        $display("test generator done");
        for (int m = 0; m < 2; m++) begin
            inv = m[0];
            bus(1'b1, 4'h0, 32'h0); // Leave master so periods restart
            c = m ? 391 : 519;
            bus(1'b1, 4'h0, m ? 32'h19 : 32'h01);
            span(1, 8);
            `CHK("clk span", 1'b1, n >= c - 2 && n <= c + 2);
            `CHK("oe", 8'hFF, tx_sys_clk_oe);
            span(2, 1);
            `CHK("frame span", 1'b1, n > 12497 && n < 12505);
        end
        do_reset(3'h7);
        $display("test master done");
        for (int t = 0; t < 5; t++) begin
            inv = mode_tab[t][3];
            lmask <= (t < 2) ? 8'hFF : 8'h01;
            bus(1'b1, 4'h0, {27'h0, mode_tab[t]});
            en = 1'b1;
            repeat (12) sample(t < 3 ? 3 : 4);
            en = 1'b0;
            $display("test slave mode %0d done", t);
        end
        print_verdict();
    end
endmodule
